// ==== rtl/iuc_ctl.sv ====
// instruction unit control: low field group with apb access, checkers and counters
//
// Notes on behaviour
// - single-issue bit forces bottom-queue-entry issue
// - short format bit shapes page entry reads
// - wide bit selects 48-bit, else 43-bit format
// - raise violation when va not sign-extended
// - wide bit vectors double miss to four-level
// - memory unit wide bit never chooses handler
// - transmit write drives clock pin; receive read-only
// - kernel enable permits reserved privileged instructions
// - upper branch bit forces not-taken prediction
// - lower branch bit forces local-only prediction while upper bit is clear
// - miss launches demand fill plus N prefetches
// - upper shadow bit maps shadow registers
// - superpage bits match memory unit meaning
// - cache set bits only block fills
// - system enable counts enabled counters only
// - process enable counts as an alternative
// - enabled counter counts on either enable
`timescale 1ns/1ns
module iuc_ctl
    import iuc_pkg::*;
#(
    parameter int CTR_W = 20
) (
    input  wire logic              MCLK,
    input  wire logic              RESET,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic                   IRQ,
    input  wire logic              VA_CHECK_VALID,
    input  wire logic [63:0]       VA_CHECK_ADDR,
    output logic                   ACCESS_VIOLATION,
    input  wire logic              DOUBLE_MISS_REQ,
    output logic                   DOUBLE_MISS_TAKEN,
    output logic                   FOUR_LEVEL_DOUBLE_MISS_ENTRY,
    input  wire logic              SERIAL_LINE_RECEIVE,
    output logic                   BOOT_SERIAL_CLOCK,
    output logic                   SINGLE_ISSUE,
    input  wire logic              KERNEL_MODE,
    output logic                   PRIV_INSTR_ALLOWED,
    input  wire logic              CHOOSER_GLOBAL,
    output iuc_bpred_t             BRANCH_PREDICT,
    input  wire logic              ICACHE_MISS,
    output logic                   ICACHE_MISS_READY,
    output logic                   DEMAND_FILL,
    output logic                   STREAM_PREFETCH,
    output logic                   SHADOW_REG_MAP,
    output logic      [2:0]        SUPERPAGE_ENABLE,
    output logic      [1:0]        ICACHE_FILL_ENABLE,
    input  wire logic [1:0]        COUNT_EVENT,
    output logic      [1:0]        COUNTER_ACTIVE
);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic                 wr_en;
    logic                 rd_hit;
    logic [NUM_EVT-1:0]   evt;
    iuc_ctl_t             ctl_q;
    iuc_ctl_t             wr_word;
    logic                 xmit_q;
    logic [NUM_EVT-1:0]   status_q;
    logic [NUM_EVT-1:0]   mask_q;
    logic                 proc_en_q;
    logic [31:0]          ptb_hi_q;
    logic [63:0]          ipe_va_q;
    logic [63:0]          ipe_fmt;
    logic [CTR_W-1:0]     ctr_q [2];

    assign PREADY  = 1'b1;
    assign wr_en   = PSEL && PENABLE && PWRITE;
    assign wr_word = iuc_ctl_t'(PWDATA[CTL_W-1:0]);

    always_comb begin
        case (PADDR)
            ADDR_CTL, ADDR_STATUS, ADDR_MASK, ADDR_PROC_CTX,
            ADDR_CTR0, ADDR_CTR1, ADDR_PTB_HI, ADDR_IPE_LO, ADDR_IPE_HI: rd_hit = 1'b1;
            default: rd_hit = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error, zero data and no side effect
    assign PSLVERR = PSEL && PENABLE && !rd_hit;

    // ------------------------------------------------------------------
    // control word
    // ------------------------------------------------------------------
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ctl_q <= iuc_ctl_t'(CTL_RESET);
        end else if (wr_en && PADDR == ADDR_CTL) begin
            // receive and transmit positions are not stored here
            ctl_q <= iuc_ctl_t'(PWDATA[CTL_W-1:0] & CTL_WR_MASK);
        end
    end

    // write-only transmit bit: latched level drives the boot serial clock pin
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            xmit_q <= 1'b0;
        end else if (wr_en && PADDR == ADDR_CTL) begin
            xmit_q <= PWDATA[BIT_XMIT];
        end
    end

    assign BOOT_SERIAL_CLOCK = xmit_q;

    // ------------------------------------------------------------------
    // plain control outputs
    // ------------------------------------------------------------------
    assign SINGLE_ISSUE       = ctl_q.single_issue;
    assign PRIV_INSTR_ALLOWED = ctl_q.privileged_instr_kernel_enable && KERNEL_MODE;
    assign SHADOW_REG_MAP     = ctl_q.shadow_register_enable[1];
    // superpage bits are passed through as-is so the fetch side decodes them like data side
    assign SUPERPAGE_ENABLE   = ctl_q.superpage_enable;
    // gates fills only; contents stay valid so re-enabling needs no flush
    assign ICACHE_FILL_ENABLE = ctl_q.icache_set_enable;

    always_comb begin
        BRANCH_PREDICT.not_taken  = ctl_q.branch_predict_select[1];
        BRANCH_PREDICT.local_only = !ctl_q.branch_predict_select[1] &&
                                    ctl_q.branch_predict_select[0];
        BRANCH_PREDICT.use_global = !ctl_q.branch_predict_select[1] &&
                                    !ctl_q.branch_predict_select[0] &&
                                    CHOOSER_GLOBAL;
    end

    // ------------------------------------------------------------------
    // sign-extension checker
    // ------------------------------------------------------------------
    logic va_bad;
    logic viol_q;
    always_comb begin
        if (ctl_q.wide_address_mode) begin
            va_bad = VA_CHECK_ADDR != {{(63-VA_WIDE_MSB){VA_CHECK_ADDR[VA_WIDE_MSB]}},
                                       VA_CHECK_ADDR[VA_WIDE_MSB:0]};
        end else begin
            va_bad = VA_CHECK_ADDR != {{(63-VA_NARROW_MSB){VA_CHECK_ADDR[VA_NARROW_MSB]}},
                                       VA_CHECK_ADDR[VA_NARROW_MSB:0]};
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            viol_q <= 1'b0;
        end else begin
            viol_q <= VA_CHECK_VALID && va_bad;
        end
    end

    assign ACCESS_VIOLATION = viol_q;

    // the checked address is also the faulting address seen by the page entry register
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ipe_va_q <= 64'h0;
        end else if (VA_CHECK_VALID) begin
            ipe_va_q <= VA_CHECK_ADDR;
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ptb_hi_q <= 32'h0;
        end else if (wr_en && PADDR == ADDR_PTB_HI) begin
            ptb_hi_q <= PWDATA;
        end
    end

    always_comb begin
        if (ctl_q.short_address_format_select) begin
            ipe_fmt = {32'h0, ptb_hi_q[31:22],
                       ipe_va_q[VA_SHORT_MSB:VA_PAGE_LSB], 3'h0};
        end else if (ctl_q.wide_address_mode) begin
            ipe_fmt = {ptb_hi_q[31:6], ipe_va_q[VA_WIDE_MSB:VA_PAGE_LSB], 3'h0};
        end else begin
            ipe_fmt = {ptb_hi_q[31:1], ipe_va_q[VA_NARROW_MSB:VA_PAGE_LSB], 3'h0};
        end
    end

    // ------------------------------------------------------------------
    // double-miss vectoring
    // ------------------------------------------------------------------
    logic dmiss_q;
    logic four_q;
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            dmiss_q <= 1'b0;
            four_q  <= 1'b0;
        end else begin
            dmiss_q <= DOUBLE_MISS_REQ;
            // only this register's wide bit decides; the memory unit copy is not an input
            if (DOUBLE_MISS_REQ) begin
                four_q <= ctl_q.wide_address_mode;
            end
        end
    end

    assign DOUBLE_MISS_TAKEN            = dmiss_q;
    assign FOUR_LEVEL_DOUBLE_MISS_ENTRY = four_q;

    // ------------------------------------------------------------------
    // miss fill sequencer
    // ------------------------------------------------------------------
    iuc_pf_state_t pf_state_q;
    logic [1:0]    pf_left_q;
    logic          demand_q;
    logic          stream_q;
    assign ICACHE_MISS_READY = pf_state_q == PF_IDLE;

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            pf_state_q <= PF_IDLE;
            pf_left_q  <= 2'h0;
            demand_q   <= 1'b0;
            stream_q   <= 1'b0;
        end else begin
            demand_q <= 1'b0;
            stream_q <= 1'b0;
            case (pf_state_q)
                PF_IDLE: begin
                    if (ICACHE_MISS) begin
                        pf_left_q  <= ctl_q.stream_prefetch_count;
                        pf_state_q <= PF_DEMAND;
                    end
                end
                PF_DEMAND: begin
                    demand_q   <= 1'b1;
                    pf_state_q <= (pf_left_q == 2'h0) ? PF_IDLE : PF_STREAM;
                end
                PF_STREAM: begin
                    stream_q  <= 1'b1;
                    pf_left_q <= pf_left_q - 2'h1;
                    if (pf_left_q == 2'h1) begin
                        pf_state_q <= PF_IDLE;
                    end
                end
                default: pf_state_q <= PF_IDLE;
            endcase
        end
    end

    assign DEMAND_FILL     = demand_q;
    assign STREAM_PREFETCH = stream_q;

    // ------------------------------------------------------------------
    // process context and performance counters
    // ------------------------------------------------------------------
    logic [1:0] ctr_en;
    logic [1:0] ovf;
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            proc_en_q <= 1'b0;
        end else if (wr_en && PADDR == ADDR_PROC_CTX) begin
            proc_en_q <= PWDATA[0];
        end
    end

    assign ctr_en = {ctl_q.counter_one_enable, ctl_q.counter_zero_enable};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ctr
            logic hit;
            assign hit = wr_en && PADDR == (i == 0 ? ADDR_CTR0 : ADDR_CTR1);
            // either enable suffices, but only for a counter whose own bit is set
            assign COUNTER_ACTIVE[i] = ctr_en[i] &&
                                       (ctl_q.system_count_enable || proc_en_q);
            // a software write in the same cycle wins, so no wrap is flagged then
            assign ovf[i] = COUNTER_ACTIVE[i] && COUNT_EVENT[i] && !hit && (&ctr_q[i]);
            always_ff @(posedge MCLK or posedge RESET) begin
                if (RESET) begin
                    ctr_q[i] <= '0;
                end else if (hit) begin
                    ctr_q[i] <= PWDATA[CTR_W-1:0];
                end else if (COUNTER_ACTIVE[i] && COUNT_EVENT[i]) begin
                    ctr_q[i] <= ctr_q[i] + 1'b1;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------------
    assign evt = {DOUBLE_MISS_REQ, ovf, VA_CHECK_VALID && va_bad};

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            status_q <= '0;
        end else begin
            // a new event in the clearing cycle stays set
            if (wr_en && PADDR == ADDR_STATUS) begin
                status_q <= (status_q & ~PWDATA[NUM_EVT-1:0]) | evt;
            end else begin
                status_q <= status_q | evt;
            end
        end
    end

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            mask_q <= '0;
        end else if (wr_en && PADDR == ADDR_MASK) begin
            mask_q <= PWDATA[NUM_EVT-1:0];
        end
    end

    assign IRQ = |(status_q & mask_q);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    logic [CTL_W-1:0] ctl_rd;
    always_comb begin
        ctl_rd           = ctl_q;
        ctl_rd[BIT_XMIT] = 1'b0;
        ctl_rd[BIT_RCV]  = SERIAL_LINE_RECEIVE;
    end

    always_comb begin
        PRDATA = 32'h0;
        if (PSEL && !PWRITE) begin
            case (PADDR)
                ADDR_CTL:      PRDATA = {{(32-CTL_W){1'b0}}, ctl_rd};
                ADDR_STATUS:   PRDATA = {{(32-NUM_EVT){1'b0}}, status_q};
                ADDR_MASK:     PRDATA = {{(32-NUM_EVT){1'b0}}, mask_q};
                ADDR_PROC_CTX: PRDATA = {31'h0, proc_en_q};
                ADDR_CTR0:     PRDATA = {{(32-CTR_W){1'b0}}, ctr_q[0]};
                ADDR_CTR1:     PRDATA = {{(32-CTR_W){1'b0}}, ctr_q[1]};
                ADDR_PTB_HI:   PRDATA = ptb_hi_q;
                ADDR_IPE_LO:   PRDATA = ipe_fmt[31:0];
                ADDR_IPE_HI:   PRDATA = ipe_fmt[63:32];
                default:       PRDATA = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);
    a_single_issue_out: assert property (
        wr_en && PADDR == ADDR_CTL |=> SINGLE_ISSUE == $past(wr_word.single_issue))
        else $error("single issue output mismatch");
    a_viol_wide_check: assert property (
        VA_CHECK_VALID && ctl_q.wide_address_mode &&
        VA_CHECK_ADDR[63:47] != {17{VA_CHECK_ADDR[47]}} |=> ACCESS_VIOLATION)
        else $error("wide violation missed");
    a_viol_narrow_ok: assert property (
        VA_CHECK_VALID && !ctl_q.wide_address_mode &&
        VA_CHECK_ADDR[63:42] == {22{VA_CHECK_ADDR[42]}} |=> !ACCESS_VIOLATION)
        else $error("narrow good address flagged");
    a_dmiss_vector: assert property (
        DOUBLE_MISS_REQ |=> DOUBLE_MISS_TAKEN &&
        FOUR_LEVEL_DOUBLE_MISS_ENTRY == $past(ctl_q.wide_address_mode))
        else $error("double miss vector wrong");
    a_xmit_pin: assert property (
        wr_en && PADDR == ADDR_CTL |=> BOOT_SERIAL_CLOCK == $past(PWDATA[BIT_XMIT]))
        else $error("serial clock pin not driven");
    a_bp_not_taken: assert property (
        ctl_q.branch_predict_select[1] |-> BRANCH_PREDICT.not_taken &&
        !BRANCH_PREDICT.use_global && !BRANCH_PREDICT.local_only)
        else $error("not taken mode broken");
    a_miss_no_prefetch: assert property (
        ICACHE_MISS && ICACHE_MISS_READY && ctl_q.stream_prefetch_count == 2'h0
        |=> ##1 DEMAND_FILL ##1 !STREAM_PREFETCH)
        else $error("prefetch launched at zero count");
    a_miss_three_pf: assert property (
        ICACHE_MISS && ICACHE_MISS_READY && ctl_q.stream_prefetch_count == 2'h3
        |=> ##1 DEMAND_FILL ##1 STREAM_PREFETCH [*3] ##1 !STREAM_PREFETCH)
        else $error("prefetch count wrong");
    a_fill_gate: assert property (
        wr_en && PADDR == ADDR_CTL |=> ICACHE_FILL_ENABLE == $past(wr_word.icache_set_enable))
        else $error("fill enable mismatch");
    a_ctr_hold: assert property (
        !COUNTER_ACTIVE[0] && !(wr_en && PADDR == ADDR_CTR0) |=> $stable(ctr_q[0]))
        else $error("disabled counter moved");
    a_ctr_either_en: assert property (
        ctl_q.counter_zero_enable && proc_en_q && !ctl_q.system_count_enable
        |-> COUNTER_ACTIVE[0])
        else $error("process enable ignored");
    c_viol_seen:   cover property (VA_CHECK_VALID && va_bad ##1 IRQ);
    c_pf_full:     cover property (DEMAND_FILL ##1 STREAM_PREFETCH [*2]);
    c_dmiss_four:  cover property (DOUBLE_MISS_TAKEN && FOUR_LEVEL_DOUBLE_MISS_ENTRY);
    c_ctr_wrap:    cover property (ovf[1]);

endmodule : iuc_ctl

// ==== rtl/iuc_pkg.sv ====
// shared constants, field layout and carrier types of the instruction unit control block
package iuc_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_CTL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_MASK     = 8'h08;
    localparam logic [7:0]  ADDR_PROC_CTX = 8'h0C;
    localparam logic [7:0]  ADDR_CTR0     = 8'h10;
    localparam logic [7:0]  ADDR_CTR1     = 8'h14;
    localparam logic [7:0]  ADDR_PTB_HI   = 8'h18;
    localparam logic [7:0]  ADDR_IPE_LO   = 8'h1C;
    localparam logic [7:0]  ADDR_IPE_HI   = 8'h20;

    // ------------------------------------------------------------------
    // control word layout
    // ------------------------------------------------------------------
    localparam int          CTL_W         = 20;
    localparam int          BIT_RCV       = 14;
    localparam int          BIT_XMIT      = 13;
    localparam logic [19:0] CTL_RESET     = 20'h00006;
    localparam logic [19:0] CTL_WR_MASK   = 20'hF9FFF;

    // status / mask bit positions
    localparam int          NUM_EVT       = 4;
    localparam int          EVT_VIOL      = 0;
    localparam int          EVT_OVF0      = 1;
    localparam int          EVT_DMISS     = 3;

    // virtual address formats
    localparam int          VA_NARROW_MSB = 42;
    localparam int          VA_WIDE_MSB   = 47;
    localparam int          VA_SHORT_MSB  = 31;
    localparam int          VA_PAGE_LSB   = 13;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       counter_one_enable;
        logic       counter_zero_enable;
        logic       single_issue;
        logic       short_address_format_select;
        logic       wide_address_mode;
        logic       serial_line_receive_bit;
        logic       serial_line_transmit_bit;
        logic       privileged_instr_kernel_enable;
        logic [1:0] branch_predict_select;
        logic [1:0] stream_prefetch_count;
        logic [1:0] shadow_register_enable;
        logic [2:0] superpage_enable;
        logic [1:0] icache_set_enable;
        logic       system_count_enable;
    } iuc_ctl_t;

    typedef struct packed {
        logic       not_taken;
        logic       local_only;
        logic       use_global;
    } iuc_bpred_t;

    typedef enum logic [1:0] {
        PF_IDLE,
        PF_DEMAND,
        PF_STREAM
    } iuc_pf_state_t;

endpackage : iuc_pkg

// ==== sim/instruction_unit_control_low_fields_tb_top.sv ====
// self-checking bench for the instruction unit control low field group
`timescale 1ns/1ns
module instruction_unit_control_low_fields_tb_top;
    import iuc_pkg::*;
    // ----------------------------------------------------------------
    // signals and design
    // ----------------------------------------------------------------
    logic        mclk, reset, psel, penable, pwrite, vvalid, dmreq, rcv, kern, chooser, miss;
    logic        pready, pslverr, irq, viol, dm_taken, dm_four, bsc, single, priv;
    logic        miss_rdy, dfill, spf, shadow, wide, perr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [63:0] vaddr, va, ie;
    logic [2:0]  spage;
    logic [1:0]  fill_en, ctr_act, cev;
    iuc_bpred_t  bp;
    int          fails, samples_checked, nd, ns;

    iuc_ctl #(.CTR_W(20)) dut (
        .MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .IRQ(irq), .VA_CHECK_VALID(vvalid), .VA_CHECK_ADDR(vaddr), .ACCESS_VIOLATION(viol),
        .DOUBLE_MISS_REQ(dmreq), .DOUBLE_MISS_TAKEN(dm_taken),
        .FOUR_LEVEL_DOUBLE_MISS_ENTRY(dm_four), .SERIAL_LINE_RECEIVE(rcv),
        .BOOT_SERIAL_CLOCK(bsc), .SINGLE_ISSUE(single), .KERNEL_MODE(kern),
        .PRIV_INSTR_ALLOWED(priv), .CHOOSER_GLOBAL(chooser), .BRANCH_PREDICT(bp),
        .ICACHE_MISS(miss), .ICACHE_MISS_READY(miss_rdy), .DEMAND_FILL(dfill),
        .STREAM_PREFETCH(spf), .SHADOW_REG_MAP(shadow), .SUPERPAGE_ENABLE(spage),
        .ICACHE_FILL_ENABLE(fill_en), .COUNT_EVENT(cev), .COUNTER_ACTIVE(ctr_act)
    );

    always #4 mclk = ~mclk;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    // request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fails++;
            give_verdict();
        end
    endtask : apb

    function automatic logic viol_exp(logic [63:0] v, logic wd);
        return wd ? (v != {{16{v[47]}}, v[47:0]}) : (v != {{21{v[42]}}, v[42:0]});
    endfunction : viol_exp

    function automatic logic [63:0] ipe_exp(logic [63:0] v, logic [31:0] b, logic s, logic wd);
        if (s) begin
            return {32'h0, b[31:22], v[31:13], 3'h0};
        end
        return wd ? {b[31:6], v[47:13], 3'h0} : {b[31:1], v[42:13], 3'h0};
    endfunction : ipe_exp

    function automatic iuc_bpred_t bp_exp(logic [1:0] m, logic ch);
        bp_exp.not_taken = m[1];
        bp_exp.local_only = !m[1] && m[0];
        bp_exp.use_global = (m == 2'b00) && ch;
    endfunction : bp_exp

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {mclk, psel, penable, pwrite, vvalid, dmreq, rcv, kern, chooser, miss} = '0;
        reset = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        vaddr = 64'h0;
        cev = 2'b00;
        fails = 0;
        samples_checked = 0;
        void'($urandom(32'h5628C2CD));
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        apb(1'b0, ADDR_CTL, 32'h0);
        check("ctl after reset", rd, 32'h00006);
        check("fill enable after reset", fill_en, 2'b11);
        apb(1'b1, 8'h3C, 32'hFFFFFFFF);
        check("unmapped error", perr, 1'b1);
        $display("test reset and unmapped done");
        for (int i = 0; i < 10; i++) begin
            w = (i == 0) ? 32'hFFFFF : (i == 1) ? 32'h00402 : ($urandom() & 32'hFFFFF);
            // both cache sets off is forbidden to software, so never sent
            if (w[2:1] == 2'b00) w[1] = 1'b1;
            rcv <= 1'($urandom());
            kern <= 1'($urandom());
            chooser <= 1'($urandom());
            cev <= 2'($urandom());
            apb(1'b1, ADDR_PROC_CTX, {31'h0, i[1]});
            apb(1'b1, ADDR_CTL, w | 32'h4000);
            apb(1'b0, ADDR_CTL, 32'h0);
            #1;
            check("ctl readback", rd, (w & 32'(CTL_WR_MASK)) | (32'(rcv) << 14));
            check("single issue", single, w[17]);
            check("serial clock", bsc, w[13]);
            check("priv allowed", priv, w[12] & kern);
            check("predict", bp, bp_exp(w[11:10], chooser));
            check("shadow", shadow, w[7]);
            check("superpage", spage, w[5:3]);
            check("fill enable", fill_en, w[2:1]);
            check("counter active", ctr_act, w[19:18] & {2{w[0] | i[1]}});
        end
        $display("test control fields done");
        for (int i = 0; i < 12; i++) begin
            wide = i[0];
            va = {$urandom(), $urandom()};
            if (i[1]) va = wide ? {{16{va[47]}}, va[47:0]} : {{21{va[42]}}, va[42:0]};
            apb(1'b1, ADDR_CTL, 32'h6 | (32'(wide) << 15) | (32'(i[3]) << 16));
            apb(1'b1, ADDR_MASK, {31'h0, i[2]});
            @(posedge mclk);
            vvalid <= 1'b1;
            vaddr <= va;
            dmreq <= 1'b1;
            @(posedge mclk);
            vvalid <= 1'b0;
            dmreq <= 1'b0;
            #1;
            check("violation", viol, viol_exp(va, wide));
            check("irq", irq, viol_exp(va, wide) & i[2]);
            check("double miss taken", dm_taken, 1'b1);
            check("four level entry", dm_four, wide);
            w = $urandom();
            apb(1'b1, ADDR_PTB_HI, w);
            ie = ipe_exp(va, w, i[3], wide);
            apb(1'b0, ADDR_IPE_LO, 32'h0);
            check("page entry low", rd, ie[31:0]);
            apb(1'b0, ADDR_IPE_HI, 32'h0);
            check("page entry high", rd, ie[63:32]);
            apb(1'b1, ADDR_STATUS, 32'hF);
            #1;
            check("irq cleared", irq, 1'b0);
        end
        $display("test address checks done");
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, ADDR_CTL, 32'h6 | (32'(n) << 8));
            @(posedge mclk);
            miss <= 1'b1;
            @(posedge mclk);
            miss <= 1'b0;
            nd = 0;
            ns = 0;
            repeat (8) begin
                @(posedge mclk);
                #1;
                nd += int'(dfill);
                ns += int'(spf);
            end
            check("demand fills", nd, 1);
            check("prefetches", ns, n);
            check("miss ready", miss_rdy, 1'b1);
        end
        $display("test miss sequencer done");
        apb(1'b1, ADDR_CTL, 32'h40007);
        apb(1'b1, ADDR_CTR0, 32'hFFFFE);
        // events start on the write edge, so a stale event pattern cannot count first
        cev <= 2'b01;
        repeat (3) @(posedge mclk);
        cev <= 2'b00;
        apb(1'b0, ADDR_CTR0, 32'h0);
        check("counter wrap", rd, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check("wrap status", rd[1], 1'b1);
        $display("test counters done");
        give_verdict();
    end
endmodule : instruction_unit_control_low_fields_tb_top
